// ---- design/psa_slave.sv ----
// supply end of the serial management bus: addressing, byte transfer, stretching
`timescale 1ns/10ps
module psa_slave
  import psa_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = STRETCH_MAX_CYC,
  parameter int unsigned LOCK_CYC = LOCKUP_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // bus pins and straps
  psa_bus_if.device bus,
  // firmware side: busy request and read data
  input wire logic busy_i,
  input wire logic [7:0] tx_data_i,
  // firmware side: received bytes and status
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_is_cmd_o,
  output logic [7:0] cmd_code_o,
  output logic cmd_vendor_o,
  output psa_target_t target_o,
  output logic rd_req_o,
  output logic invalid_cmd_o,
  output logic abort_o,
  output logic stretch_o,
  output logic [7:0] proto_rev_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} psa_slv_state_t;

  // vendor window decode
  function automatic logic is_vendor(input logic [7:0] code);
    is_vendor = (code >= VENDOR_CMD_LO) && (code <= VENDOR_CMD_HI);
  endfunction : is_vendor

  // which slave, if any, owns this address byte
  function automatic psa_target_t decode_addr(input logic [6:0] a, input logic [2:0] strap);
    if (a == {CTRL_ADDR_HI, strap}) decode_addr = TGT_CTRL;
    else if (a == {MEM_ADDR_HI, strap}) decode_addr = TGT_MEM;
    else if (a == BCAST_ADDR) decode_addr = TGT_BCAST;
    else decode_addr = TGT_NONE;
  endfunction : decode_addr

  logic scl_m_reg, scl_s_reg, scl_q_reg;
  logic sda_m_reg, sda_s_reg, sda_q_reg;
  logic [2:0] strap_m_reg, strap_s_reg, strap_lat_reg;
  psa_slv_state_t state_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_sh_reg;
  logic [3:0] bit_cnt_reg;
  logic rw_reg;
  logic first_reg;
  logic m_nack_reg;
  logic sda_oe_reg;
  logic start_pend_reg;
  logic stretch_reg;
  logic [TMO_W-1:0] str_cnt_reg;
  logic [TMO_W-1:0] lock_cnt_reg;
  logic scl_rise, scl_fall, start_det, stop_det, bus_low, lock_hit, stretch_go;
  psa_target_t addr_tgt;

  // two-flop synchronisers; pins and straps come from outside this clock
  // oversampling at 100 MHz covers both serial rates with margin
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      strap_m_reg <= 3'h7;
      strap_s_reg <= 3'h7;
    end else begin
      scl_m_reg <= bus.scl;
      scl_s_reg <= scl_m_reg;
      scl_q_reg <= scl_s_reg;
      sda_m_reg <= bus.sda;
      sda_s_reg <= sda_m_reg;
      sda_q_reg <= sda_s_reg;
      strap_m_reg <= {bus.addr_strap_bit2, bus.addr_strap_bit1, bus.addr_strap_bit0};
      strap_s_reg <= strap_m_reg;
    end
  end

  // edge and condition detection on synchronised levels only
  assign scl_rise = scl_s_reg && !scl_q_reg;
  assign scl_fall = !scl_s_reg && scl_q_reg;
  assign start_det = scl_s_reg && scl_q_reg && !sda_s_reg && sda_q_reg;
  assign stop_det = scl_s_reg && scl_q_reg && sda_s_reg && !sda_q_reg;
  assign addr_tgt = decode_addr(sh_reg[7:1], strap_lat_reg);
  assign bus_low = !scl_s_reg || !sda_s_reg;
  assign lock_hit = bus_low && (lock_cnt_reg == TMO_W'(LOCK_CYC - 1));

  // straps latched afresh at every start so a re-strap takes effect next transfer
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) strap_lat_reg <= 3'h7;
    else if (start_det) strap_lat_reg <= strap_s_reg;
  end

  // bus-stuck watchdog: any line low too long drops the transfer
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lock_cnt_reg <= '0;
      abort_o <= 1'b0;
    end else begin
      abort_o <= lock_hit;
      if (!bus_low) lock_cnt_reg <= '0;
      else if (lock_cnt_reg != TMO_W'(LOCK_CYC)) lock_cnt_reg <= lock_cnt_reg + 1'b1;
    end
  end

  // stretching engages only on the master's own falling edge, never makes an edge
  assign stretch_go = scl_fall && ((state_reg == ST_ACK) || (state_reg == ST_MACK && !m_nack_reg)
                      || start_pend_reg);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || lock_hit) begin
      start_pend_reg <= 1'b0;
    end else if (start_det) begin
      start_pend_reg <= 1'b1;
    end else if (scl_fall) begin
      start_pend_reg <= 1'b0;
    end
  end

  // hold clock low while busy, bounded so the host is never blocked too long
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || lock_hit) begin
      stretch_reg <= 1'b0;
      str_cnt_reg <= '0;
    end else if (stretch_go && busy_i && !stretch_reg) begin
      stretch_reg <= 1'b1;
      str_cnt_reg <= '0;
    end else if (stretch_reg) begin
      str_cnt_reg <= str_cnt_reg + 1'b1;
      if (!busy_i || str_cnt_reg == TMO_W'(STRETCH_CYC - 1)) stretch_reg <= 1'b0;
    end
  end

  // byte engine: address, ack, receive, transmit, master ack
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || lock_hit) begin
      state_reg <= ST_IDLE;
      sh_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      m_nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      target_o <= TGT_NONE;
    end else if (start_det) begin
      state_reg <= ST_ADDR; // repeated start too
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_s_reg};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (state_reg == ST_RX) begin
              state_reg <= ST_ACK; // writes are always acknowledged
              sda_oe_reg <= 1'b1;
              first_reg <= 1'b0;
            end else if (addr_tgt == TGT_NONE || (addr_tgt == TGT_BCAST && sh_reg[0])) begin
              state_reg <= ST_IDLE; // foreign address or broadcast read: no ack
            end else begin
              state_reg <= ST_ACK; // drives ack low; on broadcast any one ack suffices
              sda_oe_reg <= 1'b1;
              rw_reg <= sh_reg[0];
              first_reg <= !sh_reg[0];
              target_o <= addr_tgt;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_TX;
              tx_sh_reg <= tx_data_i;
              sda_oe_reg <= !tx_data_i[7];
            end else begin
              state_reg <= ST_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg <= ST_MACK;
              sda_oe_reg <= 1'b0;
            end else begin
              sda_oe_reg <= !tx_sh_reg[6];
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            m_nack_reg <= sda_s_reg;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (m_nack_reg) begin
              state_reg <= ST_IDLE; // master ends the read, wait for stop
            end else begin
              state_reg <= ST_TX;
              tx_sh_reg <= tx_data_i;
              sda_oe_reg <= !tx_data_i[7];
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // firmware-facing pulses and captured command byte
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
      rx_is_cmd_o <= 1'b0;
      cmd_code_o <= 8'h00;
      cmd_vendor_o <= 1'b0;
      rd_req_o <= 1'b0;
      invalid_cmd_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      rd_req_o <= 1'b0;
      invalid_cmd_o <= 1'b0;
      if (scl_fall && bit_cnt_reg == 4'h8 && !start_det && !stop_det && !lock_hit) begin
        if (state_reg == ST_RX) begin
          rx_valid_o <= 1'b1;
          rx_data_o <= sh_reg;
          rx_is_cmd_o <= first_reg;
          if (first_reg) begin
            cmd_code_o <= sh_reg; // standard and vendor codes both pass through
            cmd_vendor_o <= is_vendor(sh_reg);
          end
        end else if (state_reg == ST_ADDR && addr_tgt == TGT_BCAST && sh_reg[0]) begin
          invalid_cmd_o <= 1'b1;
        end
      end
      // tx_data_i is taken one cycle before this registered pulse shows
      if (scl_fall && !start_det && !stop_det && !lock_hit
          && ((state_reg == ST_ACK && rw_reg) || (state_reg == ST_MACK && !m_nack_reg))) begin
        rd_req_o <= 1'b1;
      end
    end
  end

  // open-drain pins: only ever pull low, never drive high
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe = stretch_reg;
  assign bus.dev_sda_oe = sda_oe_reg;
  assign stretch_o = stretch_reg;
  assign proto_rev_o = {PROTO_REV_MAJOR, PROTO_REV_MINOR};
endmodule : psa_slave

// ---- design/psa_pkg.sv ----
// shared constants and types for the serial management bus slave and its host
package psa_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  // address fields: upper nibble of the 7-bit address, low three bits from straps
  localparam logic [3:0] CTRL_ADDR_HI = 4'hb;
  localparam logic [3:0] MEM_ADDR_HI = 4'ha;
  localparam logic [6:0] BCAST_ADDR = 7'h00;
  localparam int unsigned NUM_STRAPS = 3;
  // vendor command window
  localparam logic [7:0] VENDOR_CMD_LO = 8'hd0;
  localparam logic [7:0] VENDOR_CMD_HI = 8'hef;
  // protocol revision spoken by the command layer (1.2)
  localparam logic [3:0] PROTO_REV_MAJOR = 4'h1;
  localparam logic [3:0] PROTO_REV_MINOR = 4'h2;
  // timing limits
  localparam int unsigned STRETCH_MAX_MS = 25;
  localparam int unsigned LOCKUP_MS = 35;
  localparam int unsigned STRETCH_MAX_CYC = STRETCH_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCKUP_CYC = LOCKUP_MS * (CLK_HZ / 1000);
  localparam int unsigned TMO_W = 22;
  // serial clock rates, standard rate is the default
  localparam int unsigned SCL_STD_HZ = 100_000;
  localparam int unsigned SCL_FAST_HZ = 400_000;
  localparam int unsigned SCL_HALF_STD = CLK_HZ / (2 * SCL_STD_HZ);
  localparam int unsigned SCL_HALF_FAST = CLK_HZ / (2 * SCL_FAST_HZ);
  localparam int unsigned HALF_W = 16;
  // which slave answered an address
  typedef enum logic [1:0] {TGT_NONE, TGT_CTRL, TGT_MEM, TGT_BCAST} psa_target_t;
  // host byte-level operations
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} psa_op_t;
endpackage : psa_pkg

// ---- design/psa_bus_if.sv ----
// open-drain serial bus wires plus strap pins joining host and supply slave
`timescale 1ns/10ps
interface psa_bus_if;
  // per-end pin signals: output level, output enable
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  // resolved wire levels, pulled high unless someone drives low
  logic scl;
  logic sda;
  // board straps: a bit is one unless tied to the return
  logic [2:0] strap_tie_low;
  logic addr_strap_bit2;
  logic addr_strap_bit1;
  logic addr_strap_bit0;

  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
  // internal pull-up: an open strap reads as one
  assign addr_strap_bit2 = !strap_tie_low[2];
  assign addr_strap_bit1 = !strap_tie_low[1];
  assign addr_strap_bit0 = !strap_tie_low[0];

  modport device (
    input scl, sda, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe
  );
  modport host (
    input scl, sda,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
  );
endinterface : psa_bus_if

// ---- design/psa_host.sv ----
// host end: bus master issuing start, byte write, byte read and stop
`timescale 1ns/10ps
module psa_host
  import psa_pkg::*;
#(
  parameter int unsigned HALF_STD = SCL_HALF_STD,
  parameter int unsigned HALF_FAST = SCL_HALF_FAST
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // bus pins
  psa_bus_if.host bus,
  // command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire psa_op_t cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic speed_fast_i,
  // answer port
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_ack_o,
  output logic rsp_err_o
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_RISE, H_HIGH, H_HOLD} psa_host_state_t;

  logic scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
  psa_host_state_t state_reg;
  psa_op_t op_reg;
  logic [7:0] sh_reg;
  logic [7:0] rd_reg;
  logic [3:0] slot_reg;
  logic nack_reg;
  logic after_start_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic [HALF_W-1:0] tmr_reg;
  logic [HALF_W-1:0] half;
  logic tmr_done;

  // default standard rate, fast rate on request
  assign half = speed_fast_i ? HALF_W'(HALF_FAST) : HALF_W'(HALF_STD);
  assign tmr_done = (tmr_reg == '0);
  assign cmd_ready_o = (state_reg == H_IDLE);

  // the wire levels are asynchronous to this clock
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      scl_m_reg <= bus.scl;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= bus.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  // bit sequencer; every clock pulse on the wire comes from here
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= H_IDLE;
      op_reg <= OP_STOP;
      sh_reg <= 8'h00;
      rd_reg <= 8'h00;
      slot_reg <= 4'h0;
      nack_reg <= 1'b0;
      after_start_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      tmr_reg <= '0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      rsp_ack_o <= 1'b0;
      rsp_err_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (!tmr_done) tmr_reg <= tmr_reg - 1'b1;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid_i) begin
            op_reg <= cmd_op_i;
            sh_reg <= cmd_data_i;
            nack_reg <= cmd_data_i[0];
            slot_reg <= 4'h0;
            tmr_reg <= half;
            if (cmd_op_i == OP_WRITE && after_start_reg && cmd_data_i == {BCAST_ADDR, 1'b1}) begin
              rsp_valid_o <= 1'b1; // broadcast read refused before it reaches the wire
              rsp_err_o <= 1'b1;
              rsp_ack_o <= 1'b0;
            end else begin
              state_reg <= H_SETUP;
              rsp_err_o <= 1'b0;
              case (cmd_op_i)
                OP_START: sda_oe_reg <= 1'b0;
                OP_WRITE: sda_oe_reg <= !cmd_data_i[7];
                OP_READ: sda_oe_reg <= 1'b0;
                OP_STOP: sda_oe_reg <= 1'b1;
                default: sda_oe_reg <= 1'b0;
              endcase
            end
          end
        end
        H_SETUP: begin
          if (tmr_done) begin
            scl_oe_reg <= 1'b0;
            state_reg <= H_RISE;
          end
        end
        H_RISE: begin
          // a stretching slave keeps the line low; wait until it lets go
          if (scl_s_reg) begin
            tmr_reg <= half;
            state_reg <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_done) begin
            tmr_reg <= half;
            case (op_reg)
              OP_START: begin
                sda_oe_reg <= 1'b1;
                state_reg <= H_HOLD;
              end
              OP_STOP: begin
                sda_oe_reg <= 1'b0;
                state_reg <= H_HOLD;
              end
              default: begin
                scl_oe_reg <= 1'b1;
                state_reg <= H_SETUP;
                slot_reg <= slot_reg + 1'b1;
                if (slot_reg == 4'h8) begin
                  state_reg <= H_IDLE;
                  rsp_valid_o <= 1'b1;
                  rsp_data_o <= rd_reg;
                  // on broadcast this only proves one supply answered
                  rsp_ack_o <= !sda_s_reg;
                  after_start_reg <= 1'b0;
                  sda_oe_reg <= (op_reg == OP_WRITE) ? 1'b0 : sda_oe_reg;
                end else if (slot_reg == 4'h7) begin
                  rd_reg <= {rd_reg[6:0], sda_s_reg};
                  sda_oe_reg <= (op_reg == OP_READ) ? !nack_reg : 1'b0;
                end else begin
                  rd_reg <= {rd_reg[6:0], sda_s_reg};
                  sh_reg <= {sh_reg[6:0], 1'b0};
                  sda_oe_reg <= (op_reg == OP_WRITE) ? !sh_reg[6] : 1'b0;
                end
              end
            endcase
          end
        end
        H_HOLD: begin
          if (tmr_done) begin
            state_reg <= H_IDLE;
            rsp_valid_o <= 1'b1;
            rsp_ack_o <= 1'b0;
            after_start_reg <= (op_reg == OP_START);
            if (op_reg == OP_START) scl_oe_reg <= 1'b1;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
      // a read releases its ack bit with the closing falling edge
      if (state_reg == H_HIGH && tmr_done && slot_reg == 4'h8 && op_reg == OP_READ) sda_oe_reg <= 1'b0;
    end
  end

  // open-drain pins only pull low
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_reg;
  assign bus.host_sda_oe = sda_oe_reg;
endmodule : psa_host

// ---- dv/psa_bus_monitor.sv ----
// wire-level checks on the serial bus between host and supply slave
`timescale 1ns/10ps
module psa_bus_monitor #(
  parameter int unsigned STRETCH_CYC = 2000,
  parameter int unsigned LOCK_CYC = 3000,
  parameter int unsigned HALF_FAST = 10
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // resolved wires and pin drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe
);
  int st_cnt_reg;
  int low_cnt_reg;
  int hi_cnt_reg;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // length of the slave's current stretch
  always_ff @(posedge sys_clk_i) begin
    st_cnt_reg <= (sys_rst_i || !dev_scl_oe) ? 0 : st_cnt_reg + 1;
  end
  // cycles with either line low, cleared only when both idle high
  always_ff @(posedge sys_clk_i) begin
    low_cnt_reg <= (sys_rst_i || (scl && sda)) ? 0 : low_cnt_reg + 1;
  end
  // clock high time, to catch a host running faster than the fast rate
  always_ff @(posedge sys_clk_i) begin
    hi_cnt_reg <= (sys_rst_i || !scl) ? 0 : hi_cnt_reg + 1;
  end
  // open drain: a pin is only ever pulled low
  property p_open_drain; (dev_scl_oe || dev_sda_oe) |-> !dev_scl_o && !dev_sda_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("slave drives a line high");
  // the slave never makes a start condition
  property p_start_host; ($fell(sda) && scl) |-> host_sda_oe; endproperty
  a_start_host: assert property (p_start_host) else $error("start not made by host");
  // slave only starts pulling data low while the clock is low
  property p_sda_scl_low; $rose(dev_sda_oe) |-> !scl; endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("slave data moved with clock high");
  // every clock fall comes from the host
  property p_host_clock; $fell(scl) |-> host_scl_oe; endproperty
  a_host_clock: assert property (p_host_clock) else $error("clock fall not from host");
  // a stretch only extends a low the host already made
  property p_stretch_low; $rose(dev_scl_oe) |-> !$past(scl); endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("stretch began on a high clock");
  // a single stretch is bounded
  property p_stretch_max; st_cnt_reg <= STRETCH_CYC + 4; endproperty
  a_stretch_max: assert property (p_stretch_max) else $error("stretch too long");
  // a stuck-low bus makes the slave let go
  property p_lockup; (low_cnt_reg == LOCK_CYC + 16) |-> !dev_scl_oe && !dev_sda_oe; endproperty
  a_lockup: assert property (p_lockup) else $error("slave still on a locked bus");
  // clock high phase never shorter than the fast rate allows
  property p_scl_high; $fell(scl) |-> hi_cnt_reg >= HALF_FAST - 2; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
endmodule : psa_bus_monitor

// ---- dv/psa_pmbus_slave_addressing_tb.sv ----
// self-checking bench: host and supply slave joined over the serial bus
`timescale 1ns/10ps
module psa_pmbus_slave_addressing_tb;
  import psa_pkg::*;
  // shortened stretch and lockup limits keep the run brief
  localparam int unsigned ST_CYC = 2000;
  localparam int unsigned LK_CYC = 3000;
  localparam logic [7:0] CMD_TAB [8] = '{8'hcf, 8'hd0, 8'hd1, 8'he7, 8'hef, 8'hf0, 8'h00, 8'h5a};
  // answer notes: {mask, {err, ack, data}}
  localparam logic [19:0] E_OK = 20'h80000;
  localparam logic [19:0] E_ACK = 20'hc0100;
  logic sys_clk_i;
  logic sys_rst_i;
  logic cmd_valid, cmd_ready, speed_fast, busy, rsp_valid, rsp_ack, rsp_err;
  logic rx_valid, rx_is_cmd, cmd_vendor, invalid_b, abort, rd_req, inv_a, stretch, st_q;
  logic [7:0] cmd_data, tx_data, rsp_data, rx_data, proto_rev, cmd_code;
  psa_op_t cmd_op;
  psa_target_t target;
  logic [19:0] rsp_q[$];
  logic [11:0] rx_q[$];
  int err_total, total_checks, cyc, inv_n, abt_n, rdq_n, st_n;
  int seed = 53;
  psa_bus_if bus();
  psa_bus_if bus_b();
  // main pair plus a second slave on a bench-driven bus
  psa_slave #(.STRETCH_CYC(ST_CYC), .LOCK_CYC(LK_CYC)) u_psa_slave (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .bus(bus.device), .busy_i(busy), .tx_data_i(tx_data), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_is_cmd_o(rx_is_cmd), .cmd_code_o(cmd_code), .cmd_vendor_o(cmd_vendor), .target_o(target),
    .rd_req_o(rd_req), .invalid_cmd_o(inv_a), .abort_o(abort), .stretch_o(stretch), .proto_rev_o(proto_rev));
  psa_slave #(.STRETCH_CYC(ST_CYC), .LOCK_CYC(LK_CYC)) u_psa_slave_b (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .bus(bus_b.device), .busy_i(busy), .tx_data_i(tx_data), .rx_valid_o(),
    .rx_data_o(), .rx_is_cmd_o(), .cmd_code_o(), .cmd_vendor_o(), .target_o(), .rd_req_o(),
    .invalid_cmd_o(invalid_b), .abort_o(), .stretch_o(), .proto_rev_o());
  psa_host #(.HALF_STD(20), .HALF_FAST(10)) u_psa_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .bus(bus.host), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
    .cmd_data_i(cmd_data), .speed_fast_i(speed_fast), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .rsp_ack_o(rsp_ack), .rsp_err_o(rsp_err));
  psa_bus_monitor #(.STRETCH_CYC(ST_CYC), .LOCK_CYC(LK_CYC), .HALF_FAST(10)) u_psa_bus_monitor (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl(bus.scl), .sda(bus.sda), .dev_scl_o(bus.dev_scl_o),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe));
  // second bus pins only ever pull low; its straps follow the main bus
  assign bus_b.host_scl_o = 1'b0;
  assign bus_b.host_sda_o = 1'b0;
  assign bus_b.strap_tie_low = bus.strap_tie_low;
  // 100 MHz system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic vend(input logic [7:0] c);
    return (c >= VENDOR_CMD_LO) && (c <= VENDOR_CMD_HI);
  endfunction : vend
  task automatic rep(input logic [11:0] e, input logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : rep
  task automatic test_done();
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // one host operation: hold the request until taken, then wait for the answer
  task automatic op(input psa_op_t o, input logic [7:0] d, input logic [19:0] e);
    rsp_q.push_back(e);
    @(posedge sys_clk_i);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    do @(posedge sys_clk_i); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge sys_clk_i); while (rsp_valid !== 1'b1);
  endtask : op
  // write transfer: address, command byte, one data byte; no data if unanswered
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input psa_target_t t);
    logic [7:0] d;
    logic ak;
    d = {1'b1, 7'($random(seed))};
    ak = (t != TGT_NONE);
    op(OP_START, 8'h00, E_OK);
    op(OP_WRITE, {a, 1'b0}, {10'h300, 1'b0, ak, 8'h00});
    if (ak) begin
      rx_q.push_back({t, 1'b1, vend(c), c});
      op(OP_WRITE, c, E_ACK);
      rx_q.push_back({t, 1'b0, vend(c), d});
      op(OP_WRITE, d, E_ACK);
    end
    op(OP_STOP, 8'h00, E_OK);
  endtask : xfer
  // addressed single-byte read ended by the host's no-ack
  task automatic rd(input logic [6:0] a);
    logic [7:0] v;
    v = 8'($random(seed));
    tx_data <= v;
    op(OP_START, 8'h00, E_OK);
    op(OP_WRITE, {a, 1'b1}, E_ACK);
    op(OP_READ, 8'h01, {10'h2ff, 2'b00, v});
    op(OP_STOP, 8'h00, E_OK);
  endtask : rd
  // bench as a rule-breaking master on the second bus: slow enough for the sync chain
  task automatic bb(input logic c, input logic s);
    @(posedge sys_clk_i);
    bus_b.host_scl_oe <= c;
    bus_b.host_sda_oe <= s;
    repeat (7) @(posedge sys_clk_i);
  endtask : bb
  // answer watcher: oldest note against each result, pulses counted
  always @(posedge sys_clk_i) begin
    if (rsp_valid === 1'b1) begin
      rsp_q.push_back(20'hfffff);
      rep({2'b00, rsp_q[0][9:0]}, {2'b00, {rsp_err, rsp_ack, rsp_data} & rsp_q[0][19:10]});
      void'(rsp_q.pop_front());
      if (rsp_q.size() > 0) void'(rsp_q.pop_back());
    end
    if (rx_valid === 1'b1) rep(rx_q.size() > 0 ? rx_q.pop_front() : 12'hfff,
      {target, rx_is_cmd, cmd_vendor, rx_data});
    if (invalid_b === 1'b1 || inv_a === 1'b1) inv_n++;
    if (abort === 1'b1) abt_n++;
    if (rd_req === 1'b1) rdq_n++;
    if (stretch === 1'b1 && st_q !== 1'b1) st_n++;
    st_q = stretch;
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  initial begin : main_seq
    int i;
    sys_rst_i = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    speed_fast = 1'b0;
    busy = 1'b0;
    tx_data = 8'h00;
    bus.strap_tie_low = 3'h0;
    bus_b.host_scl_oe = 1'b0;
    bus_b.host_sda_oe = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // every strap setting, both slaves, a near-miss address, random rate
    for (i = 0; i < 8; i++) begin
      bus.strap_tie_low <= ~i[2:0];
      speed_fast <= 1'($random(seed));
      xfer({CTRL_ADDR_HI, i[2:0]}, CMD_TAB[i], TGT_CTRL);
      xfer({MEM_ADDR_HI, i[2:0]}, CMD_TAB[7 - i], TGT_MEM);
      xfer({CTRL_ADDR_HI, ~i[2:0]}, 8'h10, TGT_NONE);
    end
    xfer(BCAST_ADDR, 8'hd7, TGT_BCAST);
    rd({CTRL_ADDR_HI, 3'h7});
    // host itself refuses a broadcast read
    op(OP_START, 8'h00, E_OK);
    op(OP_WRITE, 8'h01, 20'h80200);
    op(OP_STOP, 8'h00, E_OK);
    // slave busy for a whole transfer: stretches end at the limit
    busy <= 1'b1;
    xfer({CTRL_ADDR_HI, 3'h7}, 8'he0, TGT_CTRL);
    busy <= 1'b0;
    rep(12'h0e0, {4'h0, cmd_code});
    // host parks the clock low past the lockup time
    op(OP_START, 8'h00, E_OK);
    op(OP_WRITE, {CTRL_ADDR_HI, 3'h7, 1'b0}, E_ACK);
    repeat (LK_CYC + 100) @(posedge sys_clk_i);
    op(OP_STOP, 8'h00, E_OK);
    rep(12'h001, 12'(abt_n));
    // broadcast read on the second bus: start, address 0 with read bit, ninth clock
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    for (i = 7; i >= 0; i--) begin
      bb(1'b1, i != 0);
      bb(1'b0, i != 0);
      bb(1'b1, i != 0);
    end
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    rep(12'h001, {11'h000, bus_b.sda});
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    rep(12'h001, 12'(inv_n));
    rep(12'h012, {4'h0, proto_rev});
    rep(12'h001, 12'(rdq_n));
    rep(12'h004, 12'(st_n));
    test_done();
  end
endmodule : psa_pmbus_slave_addressing_tb
